// ==== design/dtsq_top.sv ====
// delayed trigger sequencer with its register slave
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - runs-after-main: main trigger, delay time, then acquire without delayed edge
// - delayed edge circuitry enabled only in triggerable delay modes
// - after-time: delay expires, then first delayed edge acquires
// - after-events: count delayed edges to programmed count, then acquire
// - events-then-time: count edges, then time delay, then acquire
// - pretrigger samples written continuously while qualification pending
// - after qualification capture exact posttrigger count then hand record on
// - delayed trigger is plain edge detection regardless of main type
// - triggerable mode ignores main triggers while main is logic, aux-sourced edge, or runt pulse
// - refuse triggerable mode while main settings incompatible; flag unavailable
// - choosing a triggerable type switches time base to triggerable mode
// - delayed source is channel one to four or aux input
// - five couplings: direct, capacitive, hf reject, lf reject, noise reject
// - one slope bit selects rising or falling edges
// - level free, or presets +1.4 V and -1.3 V
// - below 200 mV scale the +1.4 V and -1.3 V presets clamp to available range; the midpoint preset is not clamped
// - midpoint preset gives the average of the measured peak maximum and minimum
// - runs-after-main zone marks delayed record start through end
// - triggerable zone marks earliest start through end of main record
// - triggerable mode shows separate main and delayed level indicators
module dtsq_top
  import dtsq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic main_trig,
  input wire logic main_type_logic,
  input wire logic main_edge_aux,
  input wire logic main_pulse_runt,
  input wire logic aux_input_present,
  input wire logic [4:0] dly_cmp_async,
  input wire logic [DTSQ_LVL_W-1:0] src_pk_max,
  input wire logic [DTSQ_LVL_W-1:0] src_pk_min,
  input wire logic [DTSQ_SMP_W-1:0] sample_in,
  output logic rec_we,
  output logic [DTSQ_REC_AW-1:0] rec_addr,
  output logic [DTSQ_SMP_W-1:0] rec_data,
  output logic rec_done,
  output logic delayed_fire,
  output logic zone_mark,
  output logic [4:0] dly_src_sel,
  output logic [2:0] dly_coupling,
  output logic [DTSQ_LVL_W-1:0] dly_level,
  output logic dly_level_ind_en,
  output logic main_level_ind_en,
  output logic dly_edge_en
);
  ////////////////////////////////////////////////////////////////////
  // registers
  logic [13:0] ctrl_q;
  logic [DTSQ_CNT_W-1:0] delay_q;
  logic [DTSQ_CNT_W-1:0] events_q;
  logic [DTSQ_LVL_W-1:0] level_q;
  logic [DTSQ_LVL_W-1:0] scale_q;
  logic [DTSQ_REC_AW-1:0] post_q;
  logic [DTSQ_LVL_W-1:0] range_q;
  logic ack_q;
  logic [31:0] rdata_q;

  // a write lands in the wait cycle; the master still holds it until waitrequest drops
  wire access = (avs_read | avs_write) & ~ack_q;
  wire wr_fire = avs_write & ~ack_q;
  wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  wire incompat = main_type_logic | main_edge_aux | main_pulse_runt;
  wire [31:0] ctrl_merge = ({18'h00000, ctrl_q} & ~wmask) | (avs_writedata & wmask);
  wire wr_ctrl = wr_fire & (avs_address == DTSQ_REG_CTRL);
  // a triggerable-type pick or an explicit time base write; both refused when incompatible
  wire tb_trig_d = ctrl_merge[DTSQ_F_TBSET] ?
                   (ctrl_merge[DTSQ_F_TBTRIG] & ~incompat) :
                   (ctrl_q[DTSQ_F_TBTRIG] | (ctrl_merge[DTSQ_F_MODE+:2] !=
                    ctrl_q[DTSQ_F_MODE+:2])) & ~incompat;
  // codes past the aux input select no comparator, so they keep the old source
  wire src_bad = (ctrl_merge[DTSQ_F_SRC+:3] > 3'h4) ||
                 (ctrl_merge[DTSQ_F_SRC+:3] == 3'h4 && !aux_input_present);
  wire [2:0] src_d = src_bad ? ctrl_q[DTSQ_F_SRC+:3] : ctrl_merge[DTSQ_F_SRC+:3];
  wire [2:0] cpl_d = (ctrl_merge[DTSQ_F_CPL+:3] > 3'h4) ?
                     ctrl_q[DTSQ_F_CPL+:3] : ctrl_merge[DTSQ_F_CPL+:3];
  wire [1:0] mode_d = (ctrl_merge[DTSQ_F_MODE+:2] == DTSQ_MODE_RSV) ?
                      ctrl_q[DTSQ_F_MODE+:2] : ctrl_merge[DTSQ_F_MODE+:2];
  wire [13:0] ctrl_d = {1'b0, tb_trig_d, ctrl_merge[DTSQ_F_ZONE],
                        ctrl_merge[DTSQ_F_LSEL+:2], ctrl_merge[DTSQ_F_SLOPE],
                        cpl_d, src_d, mode_d};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= 14'h0000;
      delay_q <= 32'h00000000;
      events_q <= 32'h00000001;
      level_q <= 16'h0000;
      scale_q <= 16'h03e8;
      post_q <= 10'h200;
    end else if (wr_fire) begin
      if (wr_ctrl) ctrl_q <= ctrl_d;
      if (avs_address == DTSQ_REG_DELAY) delay_q <= (delay_q & ~wmask) | (avs_writedata & wmask);
      if (avs_address == DTSQ_REG_EVENTS) events_q <= (events_q & ~wmask) | (avs_writedata & wmask);
      if (avs_address == DTSQ_REG_LEVEL) level_q <= avs_writedata[DTSQ_LVL_W-1:0];
      if (avs_address == DTSQ_REG_SCALE) scale_q <= avs_writedata[DTSQ_LVL_W-1:0];
      if (avs_address == DTSQ_REG_POST) post_q <= avs_writedata[DTSQ_REC_AW-1:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_q <= 16'h0000;
    end else if (wr_fire && avs_address == DTSQ_REG_RANGE) begin
      range_q <= avs_writedata[DTSQ_LVL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoded controls
  wire [1:0] mode = ctrl_q[DTSQ_F_MODE+:2];
  wire tb_trig = ctrl_q[DTSQ_F_TBTRIG];
  wire slope_fall = ctrl_q[DTSQ_F_SLOPE];
  wire zone_en = ctrl_q[DTSQ_F_ZONE];
  wire [1:0] lsel = ctrl_q[DTSQ_F_LSEL+:2];

  ////////////////////////////////////////////////////////////////////
  // level presets
  wire signed [DTSQ_LVL_W-1:0] rng = range_q;
  wire signed [DTSQ_LVL_W-1:0] plus_lvl = DTSQ_LVL_PLUS_MV;
  wire signed [DTSQ_LVL_W-1:0] minus_lvl = DTSQ_LVL_MINUS_MV;
  wire small_scale = scale_q < DTSQ_SMALL_SCALE_MV;
  // range register gives the half-span the trigger comparator can reach
  wire [DTSQ_LVL_W-1:0] plus_eff = (small_scale && plus_lvl > rng) ? range_q :
                                   DTSQ_LVL_PLUS_MV;
  wire [DTSQ_LVL_W-1:0] minus_eff = (small_scale && minus_lvl < -rng) ?
                                    DTSQ_LVL_W'(-rng) : DTSQ_LVL_MINUS_MV;
  wire [DTSQ_LVL_W:0] pk_sum = {src_pk_max[DTSQ_LVL_W-1], src_pk_max} +
                               {src_pk_min[DTSQ_LVL_W-1], src_pk_min};
  wire [DTSQ_LVL_W-1:0] mid_lvl = pk_sum[DTSQ_LVL_W:1];
  wire [DTSQ_LVL_W-1:0] level_sel = (lsel == DTSQ_LVL_PLUS) ? plus_eff :
                                    (lsel == DTSQ_LVL_MINUS) ? minus_eff :
                                    (lsel == DTSQ_LVL_MID) ? mid_lvl : level_q;

  ////////////////////////////////////////////////////////////////////
  // delayed edge path
  logic edge_pulse;
  wire edge_on = tb_trig;
  // every comparator bit is brought into the clock domain before the source
  // mux, so a source change never feeds an unsettled level to the detector
  wire [4:0] cmp_sync;
  genvar gi;
  generate
    for (gi = 0; gi < $bits(dly_cmp_async); gi = gi + 1) begin : g_cmp_sync
      logic s1_q;
      logic s2_q;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= dly_cmp_async[gi];
          s2_q <= s1_q;
        end
      end
      assign cmp_sync[gi] = s2_q;
    end
  endgenerate
  logic [4:0] cmp_sel;
  assign cmp_sel = cmp_sync >> ctrl_q[DTSQ_F_SRC+:3];

  dtsq_edge u_edge (
    .clk(clk),
    .resetn(resetn),
    .cmp_async(cmp_sel[0]),
    .slope_fall(slope_fall),
    .enable(edge_on),
    .edge_pulse(edge_pulse)
  );

  logic mt_s1_q;
  logic mt_s2_q;
  logic mt_s3_q;
  wire main_rise = mt_s2_q & ~mt_s3_q;

  ////////////////////////////////////////////////////////////////////
  // sequencer
  dtsq_state_t state_q;
  dtsq_state_t state_d;
  logic [DTSQ_CNT_W-1:0] timer_q;
  logic [DTSQ_CNT_W-1:0] evcnt_q;
  logic [DTSQ_REC_AW-1:0] wptr_q;
  logic [DTSQ_REC_AW-1:0] postcnt_q;
  logic done_q;
  logic fire_q;

  // timer stops at the programmed count; a zero delay expires at once
  wire time_done = (timer_q >= delay_q);
  wire ev_done = (evcnt_q + (edge_pulse ? 32'h1 : 32'h0)) >= events_q;
  // run-after-main and after-time start by timing, the event modes by counting
  wire start_time = !tb_trig || (mode == DTSQ_AFTER_TIME);
  wire trig_ok = main_rise && !(tb_trig && incompat);
  // a main trigger while qualification is pending starts the attempt over;
  // a record already in its posttrigger part is left to finish
  wire restart = trig_ok && ((state_q == DTSQ_ARMED) || (state_q == DTSQ_COUNT) ||
                             (state_q == DTSQ_TIME) || (state_q == DTSQ_EDGE));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      DTSQ_IDLE: state_d = DTSQ_ARMED;
      DTSQ_ARMED: if (restart) state_d = start_time ? DTSQ_TIME : DTSQ_COUNT;
      DTSQ_COUNT: begin
        if (restart) begin
          state_d = start_time ? DTSQ_TIME : DTSQ_COUNT;
        end else if (ev_done) begin
          state_d = (mode == DTSQ_EVENTS_TIME) ? DTSQ_TIME : DTSQ_POST;
        end
      end
      DTSQ_TIME: begin
        if (restart) begin
          state_d = start_time ? DTSQ_TIME : DTSQ_COUNT;
        end else if (time_done) begin
          state_d = (tb_trig && mode == DTSQ_AFTER_TIME) ? DTSQ_EDGE : DTSQ_POST;
        end
      end
      DTSQ_EDGE: begin
        if (restart) state_d = start_time ? DTSQ_TIME : DTSQ_COUNT;
        else if (edge_pulse) state_d = DTSQ_POST;
      end
      DTSQ_POST: if (postcnt_q == post_q) state_d = DTSQ_ARMED;
      default: state_d = DTSQ_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mt_s1_q <= 1'b0;
      mt_s2_q <= 1'b0;
      mt_s3_q <= 1'b0;
      state_q <= DTSQ_IDLE;
    end else begin
      mt_s1_q <= main_trig;
      mt_s2_q <= mt_s1_q;
      mt_s3_q <= mt_s2_q;
      state_q <= state_d;
    end
  end

  wire in_time = (state_q == DTSQ_TIME);
  wire in_count = (state_q == DTSQ_COUNT);
  wire in_post = (state_q == DTSQ_POST);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_q <= 32'h00000000;
      evcnt_q <= 32'h00000000;
    end else if (restart) begin
      timer_q <= 32'h00000000;
      evcnt_q <= 32'h00000000;
    end else begin
      if (in_time && !time_done) timer_q <= timer_q + 32'h1;
      if (in_count && edge_pulse) evcnt_q <= evcnt_q + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_q <= 10'h000;
      postcnt_q <= 10'h000;
      rec_data <= 16'h0000;
      done_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      // the ring never pauses: a stall would overwrite the last posttrigger sample
      wptr_q <= wptr_q + 10'h001;
      rec_data <= sample_in;
      postcnt_q <= in_post ? postcnt_q + 10'h001 : 10'h000;
      done_q <= in_post && (postcnt_q == post_q);
      fire_q <= (state_q != DTSQ_POST) && (state_d == DTSQ_POST);
    end
  end

  // zone: runs-after-main ends with the record; triggerable mode holds until the next main trigger
  logic zone_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zone_q <= 1'b0;
    end else if (!zone_en || state_q == DTSQ_IDLE) begin
      zone_q <= 1'b0;
    end else if (!tb_trig) begin
      zone_q <= in_post && (postcnt_q != post_q);
    end else if (in_time && time_done || (in_count && ev_done)) begin
      zone_q <= 1'b1;
    end else if (restart) begin
      zone_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign rec_we = 1'b1;
  assign rec_addr = wptr_q;
  assign rec_done = done_q;
  assign delayed_fire = fire_q;
  assign zone_mark = zone_q;
  assign dly_src_sel = 5'h01 << ctrl_q[DTSQ_F_SRC+:3];
  assign dly_coupling = ctrl_q[DTSQ_F_CPL+:3];
  assign dly_level = level_sel;
  assign dly_level_ind_en = tb_trig;
  assign main_level_ind_en = 1'b1;
  assign dly_edge_en = edge_on;

  ////////////////////////////////////////////////////////////////////
  // bus read side; one wait cycle on every access
  wire [31:0] status_w = {24'h000000, 1'b0, incompat, zone_q, done_q, 1'b0, state_q};
  wire [31:0] rd_mux = (avs_address == DTSQ_REG_CTRL) ? {18'h00000, ctrl_q} :
                       (avs_address == DTSQ_REG_DELAY) ? delay_q :
                       (avs_address == DTSQ_REG_EVENTS) ? events_q :
                       (avs_address == DTSQ_REG_LEVEL) ? {16'h0000, level_q} :
                       (avs_address == DTSQ_REG_SCALE) ? {16'h0000, scale_q} :
                       (avs_address == DTSQ_REG_POST) ? {22'h000000, post_q} :
                       (avs_address == DTSQ_REG_STATUS) ? status_w :
                       (avs_address == DTSQ_REG_LVLOUT) ? {16'h0000, level_sel} :
                       (avs_address == DTSQ_REG_RANGE) ? {16'h0000, range_q} :
                       DTSQ_UNMAPPED;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= access;
      if (avs_read && !ack_q) rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata = rdata_q;
endmodule
`default_nettype wire

// ==== design/dtsq_pkg.sv ====
// shared constants and types for the delayed trigger sequencer
package dtsq_pkg;
  localparam int DTSQ_LVL_W = 16;
  localparam int DTSQ_CNT_W = 32;
  localparam int DTSQ_SMP_W = 16;
  localparam int DTSQ_REC_AW = 10;
  // level codes in millivolts, two's complement
  localparam logic [15:0] DTSQ_LVL_PLUS_MV = 16'h0578;
  localparam logic [15:0] DTSQ_LVL_MINUS_MV = 16'hfaec;
  localparam logic [15:0] DTSQ_SMALL_SCALE_MV = 16'h00c8;
  // register offsets (byte addresses)
  localparam logic [5:0] DTSQ_REG_CTRL = 6'h00;
  localparam logic [5:0] DTSQ_REG_DELAY = 6'h04;
  localparam logic [5:0] DTSQ_REG_EVENTS = 6'h08;
  localparam logic [5:0] DTSQ_REG_LEVEL = 6'h0c;
  localparam logic [5:0] DTSQ_REG_SCALE = 6'h10;
  localparam logic [5:0] DTSQ_REG_POST = 6'h14;
  localparam logic [5:0] DTSQ_REG_STATUS = 6'h18;
  localparam logic [5:0] DTSQ_REG_LVLOUT = 6'h1c;
  localparam logic [5:0] DTSQ_REG_RANGE = 6'h20;
  // ctrl field positions
  localparam int DTSQ_F_MODE = 0;
  localparam int DTSQ_F_SRC = 2;
  localparam int DTSQ_F_CPL = 5;
  localparam int DTSQ_F_SLOPE = 8;
  localparam int DTSQ_F_LSEL = 9;
  localparam int DTSQ_F_ZONE = 11;
  localparam int DTSQ_F_TBTRIG = 12;
  localparam int DTSQ_F_TBSET = 13;
  localparam logic [31:0] DTSQ_UNMAPPED = 32'h00000000;

  typedef enum logic [1:0] {
    DTSQ_AFTER_TIME = 2'b00,
    DTSQ_AFTER_EVENTS = 2'b01,
    DTSQ_EVENTS_TIME = 2'b10,
    DTSQ_MODE_RSV = 2'b11
  } dtsq_mode_t;

  typedef enum logic [1:0] {
    DTSQ_LVL_FREE = 2'b00,
    DTSQ_LVL_PLUS = 2'b01,
    DTSQ_LVL_MINUS = 2'b10,
    DTSQ_LVL_MID = 2'b11
  } dtsq_lsel_t;

  typedef enum logic [2:0] {
    DTSQ_IDLE = 3'b000,
    DTSQ_ARMED = 3'b001,
    DTSQ_COUNT = 3'b010,
    DTSQ_TIME = 3'b011,
    DTSQ_EDGE = 3'b100,
    DTSQ_POST = 3'b101
  } dtsq_state_t;
endpackage

// ==== design/dtsq_edge.sv ====
// plain edge detector on the delayed trigger comparator output
`timescale 1ns/1ps
`default_nettype none
module dtsq_edge (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cmp_async,
  input wire logic slope_fall,
  input wire logic enable,
  output logic edge_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  wire rise = s2_q & ~s3_q;
  wire fall = ~s2_q & s3_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= cmp_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // output gated so no edge pulse leaves outside triggerable mode; the sync stages keep sampling
  assign edge_pulse = enable & (slope_fall ? fall : rise);
endmodule
`default_nettype wire

// ==== tb/dtsq_top_sva.sv ====
// port assertions for the delayed trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module dtsq_top_sva
  import dtsq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic main_type_logic,
  input wire logic main_edge_aux,
  input wire logic main_pulse_runt,
  input wire logic [DTSQ_SMP_W-1:0] sample_in,
  input wire logic rec_we,
  input wire logic [DTSQ_REC_AW-1:0] rec_addr,
  input wire logic [DTSQ_SMP_W-1:0] rec_data,
  input wire logic rec_done,
  input wire logic delayed_fire,
  input wire logic dly_level_ind_en,
  input wire logic main_level_ind_en,
  input wire logic dly_edge_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic incompat = main_type_logic | main_edge_aux | main_pulse_runt;
  ////////////////////////////////////////
  property p_main_ind; main_level_ind_en; endproperty
  a_main_ind: assert property (p_main_ind) else $error("main indicator off");
  property p_dly_ind; dly_level_ind_en == dly_edge_en; endproperty
  a_dly_ind: assert property (p_dly_ind) else $error("delayed indicator mismatch");
  // a qualification already running may still finish, hence the settle time
  property p_blocked; (incompat && dly_edge_en) [*8] |-> !delayed_fire; endproperty
  a_blocked: assert property (p_blocked) else $error("fired while incompatible");
  property p_we; rec_we; endproperty
  a_we: assert property (p_we) else $error("record writes stopped");
  property p_addr; $past(resetn) |-> rec_addr == $past(rec_addr) + 1'b1; endproperty
  a_addr: assert property (p_addr) else $error("record pointer stalled");
  property p_data; $past(resetn) |-> rec_data == $past(sample_in); endproperty
  a_data: assert property (p_data) else $error("record data not last sample");
  property p_fire_one; delayed_fire |=> !delayed_fire; endproperty
  a_fire_one: assert property (p_fire_one) else $error("fire pulse too long");
  property p_fire_done; delayed_fire |-> ##[2:300] rec_done; endproperty
  a_fire_done: assert property (p_fire_done) else $error("record never done");
  property p_done_one; rec_done |=> !rec_done; endproperty
  a_done_one: assert property (p_done_one) else $error("done pulse too long");
endmodule
bind dtsq_top dtsq_top_sva u_sva (.clk(clk), .resetn(resetn),
  .main_type_logic(main_type_logic), .main_edge_aux(main_edge_aux),
  .main_pulse_runt(main_pulse_runt), .sample_in(sample_in), .rec_we(rec_we),
  .rec_addr(rec_addr), .rec_data(rec_data), .rec_done(rec_done),
  .delayed_fire(delayed_fire), .dly_level_ind_en(dly_level_ind_en),
  .main_level_ind_en(main_level_ind_en), .dly_edge_en(dly_edge_en));
`default_nettype wire

// ==== tb/dtsq_partner.sv ====
// main trigger source and acquisition record memory
`timescale 1ns/1ps
`default_nettype none
module dtsq_partner
  import dtsq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic rec_we,
  input wire logic [DTSQ_REC_AW-1:0] rec_addr,
  input wire logic [DTSQ_SMP_W-1:0] rec_data,
  input wire logic rec_done,
  output logic main_trig,
  output logic [DTSQ_SMP_W-1:0] sample_in
);
  logic [DTSQ_SMP_W-1:0] mem [0:(1<<DTSQ_REC_AW)-1];
  int n_rec;
  initial main_trig = 1'b0;
  // ramp samples so a stale or skipped write is visible
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_in <= 16'h0000;
      n_rec <= 0;
    end else begin
      sample_in <= sample_in + 16'h0001;
      if (rec_we) mem[rec_addr] <= rec_data;
      if (rec_done) n_rec <= n_rec + 1;
    end
  end
  // held several cycles so the two-stage sync cannot miss it
  task automatic trig();
    @(posedge clk);
    main_trig <= 1'b1;
    repeat (4) @(posedge clk);
    main_trig <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/dtsq_top_tb.sv ====
// register and sequencing tests for the delayed trigger sequencer
`timescale 1ns/1ps
`default_nettype none
module dtsq_top_tb
  import dtsq_pkg::*;
;
  localparam int POST = 4;
  localparam int DLY = 40;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [2:0] inc = 3'h0;
  logic aux_on = 1'b0;
  logic [4:0] cmp = 5'h00;
  logic [15:0] pk_max = 16'h0258;
  logic [15:0] pk_min = 16'hff38;
  logic [31:0] avs_readdata, q;
  logic [15:0] smp, rec_data, dly_level;
  logic [DTSQ_REC_AW-1:0] rec_addr;
  logic [4:0] src_sel;
  logic [2:0] cpl;
  logic avs_waitrequest, main_trig, rec_we, rec_done, delayed_fire, zone_mark;
  logic dly_level_ind_en, main_level_ind_en, dly_edge_en;
  int fail_count = 0, n_compared = 0, n_fire = 0, f0 = 0, cyc = 0, t_fire = 0;
  always #10 clk = ~clk;
  dtsq_top uut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_trig(main_trig), .main_type_logic(inc[0]), .main_edge_aux(inc[1]),
    .main_pulse_runt(inc[2]), .aux_input_present(aux_on), .dly_cmp_async(cmp),
    .src_pk_max(pk_max), .src_pk_min(pk_min), .sample_in(smp), .rec_we(rec_we),
    .rec_addr(rec_addr), .rec_data(rec_data), .rec_done(rec_done),
    .delayed_fire(delayed_fire), .zone_mark(zone_mark), .dly_src_sel(src_sel),
    .dly_coupling(cpl), .dly_level(dly_level), .dly_level_ind_en(dly_level_ind_en),
    .main_level_ind_en(main_level_ind_en), .dly_edge_en(dly_edge_en));
  dtsq_partner partner (.clk(clk), .resetn(resetn), .rec_we(rec_we), .rec_addr(rec_addr),
    .rec_data(rec_data), .rec_done(rec_done), .main_trig(main_trig), .sample_in(smp));
  ////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one access; held until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k == 20) begin
      fail_count++;
      wrap_up();
    end
  endtask
  function automatic logic [31:0] ctl(input int m, s, c, f, l, z, t, e);
    return 32'(m) << DTSQ_F_MODE | 32'(s) << DTSQ_F_SRC | 32'(c) << DTSQ_F_CPL |
      32'(f) << DTSQ_F_SLOPE | 32'(l) << DTSQ_F_LSEL | 32'(z) << DTSQ_F_ZONE |
      32'(t) << DTSQ_F_TBTRIG | 32'(e) << DTSQ_F_TBSET;
  endfunction
  task automatic edg(input int n);
    repeat (n) begin
      @(posedge clk);
      cmp[0] <= 1'b1;
      repeat (6) @(posedge clk);
      cmp[0] <= 1'b0;
      repeat (5) @(posedge clk);
    end
  endtask
  task automatic trg();
    repeat (10) @(posedge clk);
    f0 = n_fire;
    partner.trig();
  endtask
  task automatic quiet(input int n);
    repeat (n) @(posedge clk);
    chk(n_fire, f0);
  endtask
  task automatic fired(input int n);
    int k;
    for (k = 0; k < n && n_fire == f0; k++) @(posedge clk);
    chk(n_fire, f0 + 1);
    f0 = n_fire;
  endtask
  // counted on the falling edge, clear of the driving edge
  always @(negedge clk) begin
    cyc++;
    if (delayed_fire === 1'b1) begin
      n_fire++;
      t_fire = cyc;
    end
    if (rec_done === 1'b1) chk(32'(cyc - t_fire >= POST + 1 && cyc - t_fire <= POST + 2), 32'h1);
  end
  ////////////////////////////////////////
  initial begin
    int i;
    logic [15:0] lv [4];
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    acc(1'b0, DTSQ_REG_SCALE, 32'h0);
    chk(q, 32'h000003e8);
    acc(1'b0, 6'h3c, 32'h0);
    chk(q, DTSQ_UNMAPPED);
    acc(1'b1, DTSQ_REG_DELAY, DLY);
    acc(1'b1, DTSQ_REG_EVENTS, 32'h3);
    acc(1'b1, DTSQ_REG_POST, POST);
    acc(1'b1, DTSQ_REG_LEVEL, 32'h0123);
    lv[0] = 16'h0123;
    lv[1] = DTSQ_LVL_PLUS_MV;
    lv[2] = DTSQ_LVL_MINUS_MV;
    lv[3] = 16'(($signed(pk_max) + $signed(pk_min)) >>> 1);
    for (i = 0; i < 4; i++) begin
      acc(1'b1, DTSQ_REG_CTRL, ctl(0, 0, 0, 0, i, 0, 0, 0));
      chk(dly_level, lv[i]);
    end
    acc(1'b1, DTSQ_REG_SCALE, 32'h64);
    acc(1'b1, DTSQ_REG_RANGE, 32'h1f4);
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 0, 0, 0, 1, 0, 0, 0));
    chk(dly_level, 16'h01f4);
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 0, 0, 0, 2, 0, 0, 0));
    chk(dly_level, 16'(16'h0000 - 16'h01f4));
    acc(1'b1, DTSQ_REG_SCALE, 32'h3e8);
    for (i = 0; i < 4; i++) begin
      acc(1'b1, DTSQ_REG_CTRL, ctl(0, i, i, 0, 0, 0, 0, 0));
      chk(src_sel, 32'(5'h01 << i));
      chk(cpl, i);
    end
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 4, 3, 0, 0, 0, 0, 0));
    chk(src_sel, 5'h08);
    aux_on <= 1'b1;
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 4, 4, 0, 0, 0, 0, 0));
    chk(src_sel, 5'h10);
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 4, 5, 0, 0, 0, 0, 0));
    chk(cpl, 3'h4);
    acc(1'b1, DTSQ_REG_CTRL, ctl(1, 0, 0, 0, 0, 1, 0, 0));
    chk(dly_edge_en, 1'b1);
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 0));
    acc(1'b0, DTSQ_REG_CTRL, 32'h0);
    chk(q[12], 1'b1);
    trg();
    edg(1);
    quiet(40);
    chk(zone_mark, 1'b1);
    edg(1);
    fired(30);
    acc(1'b1, DTSQ_REG_CTRL, ctl(1, 0, 0, 0, 0, 0, 0, 0));
    trg();
    edg(2);
    quiet(10);
    trg();
    edg(2);
    quiet(10);
    edg(1);
    fired(20);
    acc(1'b1, DTSQ_REG_CTRL, ctl(2, 0, 0, 0, 0, 0, 0, 0));
    trg();
    edg(3);
    quiet(20);
    fired(40);
    acc(1'b1, DTSQ_REG_EVENTS, 32'h1);
    acc(1'b1, DTSQ_REG_CTRL, ctl(1, 0, 0, 1, 0, 0, 0, 0));
    trg();
    cmp[0] <= 1'b1;
    quiet(20);
    cmp[0] <= 1'b0;
    fired(20);
    acc(1'b1, DTSQ_REG_CTRL, ctl(0, 0, 0, 0, 0, 1, 0, 1));
    chk(dly_edge_en, 1'b0);
    trg();
    quiet(20);
    chk(zone_mark, 1'b0);
    fired(40);
    for (i = 0; i < 3; i++) begin
      acc(1'b1, DTSQ_REG_CTRL, ctl(1, 0, 0, 0, 0, 0, 1, 1));
      inc <= 3'(1 << i);
      trg();
      edg(1);
      quiet(30);
      acc(1'b1, DTSQ_REG_CTRL, ctl(1, 0, 0, 0, 0, 0, 1, 1));
      acc(1'b0, DTSQ_REG_CTRL, 32'h0);
      chk(q[12], 1'b0);
      acc(1'b0, DTSQ_REG_STATUS, 32'h0);
      chk(q[6], 1'b1);
      inc <= 3'h0;
    end
    chk(partner.n_rec, n_fire);
    wrap_up();
  end
endmodule
`default_nettype wire
